// ### design/spcr_defines.vh
`ifndef SPCR_DEFINES_VH
`define SPCR_DEFINES_VH

// ----------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------
`define SPCR_OFF_SETUP_A 15'h0000
`define SPCR_OFF_SETUP_B 15'h0001
`define SPCR_OFF_POWER 15'h0002
`define SPCR_OFF_CLASS 15'h0003
`define SPCR_OFF_PART_LOW 15'h0004
`define SPCR_OFF_UPDATE 15'h000f
`define SPCR_OFF_PD0 15'h00b2
`define SPCR_OFF_PD1 15'h00b3
`define SPCR_OFF_CONV_BASE 15'h0050
`define SPCR_OFF_CONV_TOP 15'h006f

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define SPCR_RST_SETUP_A 7'h30
`define SPCR_RST_SETUP_B 8'h00
`define SPCR_RST_POWER 8'h03
`define SPCR_RST_UPDATE 7'h00
`define SPCR_RST_PD 8'h00

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define SPCR_BIT_SOFT_RESET 7
`define SPCR_BIT_ASCEND 5
`define SPCR_BIT_SINGLE 7
`define SPCR_BIT_SOURCE 5
`define SPCR_BIT_LOAD 0
`define SPCR_POWER_MSB 1
`define SPCR_POWER_FULL 2'h0
`define SPCR_POWER_DOWN 2'h3
`define SPCR_PD_ALL_OFF 8'hff

// ----------------------------------------------------------------
// serial frame layout
// ----------------------------------------------------------------
`define SPCR_INSTR_LAST 4'hf
`define SPCR_BYTE_LAST 4'h7
`define SPCR_RW_BIT 15

`endif

// ### design/spcr_conv_store.v
`include "spcr_defines.vh"

module spcr_conv_store #(
  parameter AW = 5,
  parameter DEPTH = 32
) (
  // clock and reset
  input wire ref_clk_in,
  input wire clear_in,
  // serial side
  input wire wr_en_in,
  input wire [AW-1:0] wr_addr_in,
  input wire [7:0] wr_data_in,
  input wire load_in,
  input wire source_buf_in,
  input wire [AW-1:0] rd_addr_in,
  output reg [7:0] rd_data_out,
  // converter side
  input wire [AW-1:0] act_addr_in,
  output reg [7:0] act_data_out
);

  reg [7:0] buf_mem [0:DEPTH-1];
  reg [7:0] act_mem [0:DEPTH-1];
  integer i;

  // ----------------------------------------------------------------
  // buffered and active banks
  // ----------------------------------------------------------------
  always @(posedge ref_clk_in) begin
    if (clear_in) begin
      for (i = 0; i < DEPTH; i = i + 1) begin
        buf_mem[i] <= 8'h00;
        act_mem[i] <= 8'h00;
      end
      rd_data_out <= 8'h00;
      act_data_out <= 8'h00;
    end else begin
      if (wr_en_in) begin
        buf_mem[wr_addr_in] <= wr_data_in;
      end
      if (load_in) begin
        // copy every buffered byte at once
        for (i = 0; i < DEPTH; i = i + 1) begin
          act_mem[i] <= buf_mem[i];
        end
      end
      rd_data_out <= source_buf_in ? buf_mem[rd_addr_in] :
                     act_mem[rd_addr_in];
      act_data_out <= act_mem[act_addr_in];
    end
  end

endmodule // spcr_conv_store

// ### design/spcr_regs.v
`include "spcr_defines.vh"

module spcr_regs #(
  parameter [3:0] CLASS_CODE = 4'h5, // arbitrary value
  parameter [7:0] PART_CODE_LOW = 8'ha5, // arbitrary value
  parameter CONV_AW = 5,
  parameter CONV_DEPTH = 32
) (
  // clock and reset
  input wire ref_clk_in,
  input wire srst_in,
  // serial port, sampled on ref_clk_in
  input wire spi_cs_n_in,
  input wire spi_sclk_in,
  input wire spi_sdi_in,
  output reg spi_sdo_out,
  output reg spi_sdo_oe_out,
  // device controls
  output reg soft_reset_out,
  output reg converter_load_out,
  output reg converter_source_a_out,
  output reg [1:0] power_state_out,
  output reg [7:0] power_down_0_out,
  output reg [7:0] power_down_1_out,
  // converter read of active data
  input wire [CONV_AW-1:0] conv_addr_in,
  output wire [7:0] conv_data_out
);

  localparam [3:0] ST_IDLE = 4'h1;
  localparam [3:0] ST_INSTR = 4'h2;
  localparam [3:0] ST_DATA = 4'h4;
  localparam [3:0] ST_HOLD = 4'h8;

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  reg [3:0] state;
  reg sclk_q;
  reg [3:0] bit_cnt;
  reg [14:0] shift_in;
  reg [7:0] data_in;
  reg is_read;
  reg [14:0] addr;
  reg [7:0] rd_byte;
  reg [6:0] setup_a;
  reg [7:0] setup_b;
  reg [7:0] power_reg;
  reg [6:0] update_reg;
  reg wr_en;
  reg [14:0] wr_addr;
  reg [7:0] wr_data;
  wire [7:0] conv_rd;
  wire sclk_rise;
  wire sclk_fall;
  wire clear_all;
  wire ascend;
  wire [15:0] instr_word;
  wire [7:0] byte_word;
  wire wr_conv;

  assign sclk_rise = spi_sclk_in & ~sclk_q;
  assign sclk_fall = ~spi_sclk_in & sclk_q;
  assign clear_all = srst_in | soft_reset_out;
  assign ascend = setup_a[`SPCR_BIT_ASCEND];
  assign instr_word = {shift_in, spi_sdi_in};
  assign byte_word = {data_in[6:0], spi_sdi_in};
  assign wr_conv = wr_en & in_conv(wr_addr);

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function in_conv;
    input [14:0] a;
    begin
      in_conv = (a >= `SPCR_OFF_CONV_BASE) && (a <= `SPCR_OFF_CONV_TOP);
    end
  endfunction

  function [CONV_AW-1:0] conv_index;
    input [14:0] a;
    reg [14:0] d;
    begin
      d = a - `SPCR_OFF_CONV_BASE;
      conv_index = d[CONV_AW-1:0];
    end
  endfunction

  function [14:0] step_addr;
    input [14:0] a;
    input up;
    begin
      // 15-bit arithmetic wraps at both ends
      step_addr = up ? a + 15'h0001 : a - 15'h0001;
    end
  endfunction

  // ----------------------------------------------------------------
  // serial frame engine
  // ----------------------------------------------------------------
  always @(posedge ref_clk_in) begin
    if (srst_in) begin
      state <= ST_IDLE;
      sclk_q <= 1'b0;
      bit_cnt <= 4'h0;
      shift_in <= 15'h0000;
      data_in <= 8'h00;
      is_read <= 1'b0;
      addr <= 15'h0000;
      wr_en <= 1'b0;
      wr_addr <= 15'h0000;
      wr_data <= 8'h00;
      spi_sdo_out <= 1'b0;
      spi_sdo_oe_out <= 1'b0;
    end else begin
      sclk_q <= spi_sclk_in;
      wr_en <= 1'b0;
      if (spi_cs_n_in) begin
        state <= ST_IDLE;
        spi_sdo_oe_out <= 1'b0;
        spi_sdo_out <= 1'b0;
      end else begin
        case (state)
          ST_IDLE: begin
            state <= ST_INSTR;
            bit_cnt <= 4'h0;
            if (sclk_rise) begin
              shift_in <= {14'h0000, spi_sdi_in};
              bit_cnt <= 4'h1;
            end
          end
          ST_INSTR: begin
            if (sclk_rise) begin
              shift_in <= instr_word[14:0];
              bit_cnt <= bit_cnt + 4'h1;
              if (bit_cnt == `SPCR_INSTR_LAST) begin
                is_read <= instr_word[`SPCR_RW_BIT];
                addr <= instr_word[14:0];
                bit_cnt <= 4'h0;
                state <= ST_DATA;
              end
            end
          end
          ST_DATA: begin
            if (sclk_fall && is_read) begin
              spi_sdo_oe_out <= 1'b1;
              spi_sdo_out <= rd_byte[~bit_cnt[2:0]];
            end
            if (sclk_rise) begin
              data_in <= byte_word;
              bit_cnt <= bit_cnt + 4'h1;
              if (bit_cnt == `SPCR_BYTE_LAST) begin
                bit_cnt <= 4'h0;
                wr_en <= ~is_read;
                wr_addr <= addr;
                wr_data <= byte_word;
                addr <= step_addr(addr, ascend);
                if (setup_b[`SPCR_BIT_SINGLE]) begin
                  state <= ST_HOLD;
                end
              end
            end
          end
          ST_HOLD: begin
            // single access: rest of frame is ignored
            if (sclk_fall) begin
              spi_sdo_oe_out <= 1'b0;
            end
          end
          default: begin
            state <= ST_IDLE;
          end
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // interface setup registers (kept through soft reset)
  // ----------------------------------------------------------------
  always @(posedge ref_clk_in) begin
    if (srst_in) begin
      setup_a <= `SPCR_RST_SETUP_A;
      setup_b <= `SPCR_RST_SETUP_B;
      soft_reset_out <= 1'b0;
      converter_source_a_out <= 1'b0;
    end else begin
      soft_reset_out <= 1'b0;
      if (wr_en && wr_addr == `SPCR_OFF_SETUP_A) begin
        setup_a <= wr_data[6:0];
        soft_reset_out <= wr_data[`SPCR_BIT_SOFT_RESET];
      end
      if (wr_en && wr_addr == `SPCR_OFF_SETUP_B) begin
        setup_b <= wr_data;
        converter_source_a_out <= wr_data[`SPCR_BIT_SOURCE];
      end
    end
  end

  // ----------------------------------------------------------------
  // power and update registers
  // ----------------------------------------------------------------
  always @(posedge ref_clk_in) begin
    if (clear_all) begin
      power_reg <= `SPCR_RST_POWER;
      power_state_out <= `SPCR_POWER_DOWN;
      power_down_0_out <= `SPCR_RST_PD;
      power_down_1_out <= `SPCR_RST_PD;
      update_reg <= `SPCR_RST_UPDATE;
      converter_load_out <= 1'b0;
    end else begin
      converter_load_out <= 1'b0;
      if (wr_en && wr_addr == `SPCR_OFF_POWER) begin
        power_reg <= wr_data;
        power_state_out <= wr_data[`SPCR_POWER_MSB:0];
        // one-time override of the per-block power-downs
        if (wr_data[`SPCR_POWER_MSB:0] == `SPCR_POWER_DOWN) begin
          power_down_0_out <= `SPCR_PD_ALL_OFF;
          power_down_1_out <= `SPCR_PD_ALL_OFF;
        end else if (wr_data[`SPCR_POWER_MSB:0] == `SPCR_POWER_FULL) begin
          power_down_0_out <= `SPCR_RST_PD;
          power_down_1_out <= `SPCR_RST_PD;
        end
      end
      if (wr_en && wr_addr == `SPCR_OFF_PD0) begin
        power_down_0_out <= wr_data;
      end
      if (wr_en && wr_addr == `SPCR_OFF_PD1) begin
        power_down_1_out <= wr_data;
      end
      if (wr_en && wr_addr == `SPCR_OFF_UPDATE) begin
        update_reg <= wr_data[7:1];
        converter_load_out <= wr_data[`SPCR_BIT_LOAD];
      end
    end
  end

  // ----------------------------------------------------------------
  // read data, one cycle behind the address (two for the converter store)
  // ----------------------------------------------------------------
  always @(posedge ref_clk_in) begin
    if (srst_in) begin
      rd_byte <= 8'h00;
    end else if (in_conv(addr)) begin
      rd_byte <= conv_rd;
    end else begin
      case (addr)
        `SPCR_OFF_SETUP_A: rd_byte <= {1'b0, setup_a};
        `SPCR_OFF_SETUP_B: rd_byte <= setup_b;
        `SPCR_OFF_POWER: rd_byte <= power_reg;
        `SPCR_OFF_CLASS: rd_byte <= {4'h0, CLASS_CODE};
        `SPCR_OFF_PART_LOW: rd_byte <= PART_CODE_LOW;
        `SPCR_OFF_UPDATE: rd_byte <= {update_reg, 1'b0};
        `SPCR_OFF_PD0: rd_byte <= power_down_0_out;
        `SPCR_OFF_PD1: rd_byte <= power_down_1_out;
        default: rd_byte <= 8'h00;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // converter data store
  // ----------------------------------------------------------------
  spcr_conv_store #(
    .AW(CONV_AW),
    .DEPTH(CONV_DEPTH)
  ) u_store (
    .ref_clk_in(ref_clk_in),
    .clear_in(clear_all),
    .wr_en_in(wr_conv),
    .wr_addr_in(conv_index(wr_addr)),
    .wr_data_in(wr_data),
    .load_in(converter_load_out),
    .source_buf_in(setup_b[`SPCR_BIT_SOURCE]),
    .rd_addr_in(conv_index(addr)),
    .rd_data_out(conv_rd),
    .act_addr_in(conv_addr_in),
    .act_data_out(conv_data_out)
  );

endmodule // spcr_regs

// ### sim/spcr_regs_monitor.sv
module spcr_regs_monitor #(
  parameter CONV_AW = 5
) (
  // clock and reset
  input wire ref_clk_in,
  input wire srst_in,
  // serial port
  input wire spi_cs_n_in,
  input wire spi_sclk_in,
  input wire spi_sdo_out,
  input wire spi_sdo_oe_out,
  // device controls
  input wire soft_reset_out,
  input wire converter_load_out,
  input wire [1:0] power_state_out,
  input wire [7:0] power_down_0_out,
  input wire [7:0] power_down_1_out,
  // converter
  input wire [CONV_AW-1:0] conv_addr_in
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge ref_clk_in);
  endclocking
  default disable iff (srst_in);

  property p_sr_pulse;
    soft_reset_out |=> !soft_reset_out;
  endproperty
  a_sr_pulse: assert property (p_sr_pulse)
    else $error("soft reset pulse too long");
  property p_sr_clear;
    soft_reset_out |-> ##[1:2] (power_state_out == 2'h3 &&
      power_down_0_out == 8'h00 && power_down_1_out == 8'h00);
  endproperty
  a_sr_clear: assert property (p_sr_clear)
    else $error("soft reset left power registers set");
  property p_load_pulse;
    converter_load_out |=> !converter_load_out;
  endproperty
  a_load_pulse: assert property (p_load_pulse)
    else $error("load pulse too long");
  property p_pd_zero;
    $changed(power_state_out) && power_state_out == 2'h0 |->
      power_down_0_out == 8'h00 && power_down_1_out == 8'h00;
  endproperty
  a_pd_zero: assert property (p_pd_zero)
    else $error("full power left power-down bits set");
  property p_oe_rel;
    spi_cs_n_in && $past(spi_cs_n_in) |-> !spi_sdo_oe_out;
  endproperty
  a_oe_rel: assert property (p_oe_rel)
    else $error("sdo driven outside a frame");
  property p_sdo_hold;
    spi_sclk_in && $past(spi_sclk_in) && $past(spi_sclk_in, 2) &&
      $past(spi_sclk_in, 3) && !spi_cs_n_in |-> $stable(spi_sdo_out);
  endproperty
  a_sdo_hold: assert property (p_sdo_hold)
    else $error("sdo changed while sclk high");
  property p_oe_rise;
    $rose(spi_sdo_oe_out) |-> !spi_cs_n_in && !spi_sclk_in;
  endproperty
  a_oe_rise: assert property (p_oe_rise)
    else $error("sdo enabled at the wrong moment");
  property p_ps_frame;
    $changed(power_state_out) |-> !$past(spi_cs_n_in, 2);
  endproperty
  a_ps_frame: assert property (p_ps_frame)
    else $error("power state changed outside a frame");
  property p_rst_ps;
    $fell(srst_in) |-> power_state_out == 2'h3 && !spi_sdo_oe_out;
  endproperty
  a_rst_ps: assert property (p_rst_ps)
    else $error("power state not lowest after reset");
endmodule // spcr_regs_monitor

bind spcr_regs spcr_regs_monitor #(.CONV_AW(CONV_AW)) u_mon (
  .ref_clk_in, .srst_in, .spi_cs_n_in, .spi_sclk_in, .spi_sdo_out,
  .spi_sdo_oe_out, .soft_reset_out, .converter_load_out,
  .power_state_out, .power_down_0_out, .power_down_1_out, .conv_addr_in);

// ### sim/spcr_host.sv
module spcr_host (
  // clock
  input wire ref_clk_in,
  // serial port
  input wire spi_sdo_in,
  input wire spi_sdo_oe_in,
  output logic spi_cs_n_out = 1'b1,
  output logic spi_sclk_out = 1'b0,
  output logic spi_sdi_out = 1'b0,
  // read results
  output logic rd_valid_out = 1'b0,
  output logic [7:0] rd_byte_out = 8'h00
);
  timeunit 1ns;
  timeprecision 1ns;

  // one bit: 4 clocks low then 4 high; released sdo reads inverted
  task automatic bit_io(input logic b, output logic q);
    spi_sclk_out <= 1'b0;
    spi_sdi_out <= b;
    repeat (4) @(posedge ref_clk_in);
    q = spi_sdo_oe_in ? spi_sdo_in : ~spi_sdo_in;
    spi_sclk_out <= 1'b1;
    repeat (4) @(posedge ref_clk_in);
  endtask

  // first byte in bits 7:0 of wd
  task automatic xfer(input logic rd, input logic [14:0] a, input int n,
                      input logic [39:0] wd);
    logic [15:0] ins;
    logic [7:0] q;
    logic b;
    ins = {rd, a};
    spi_cs_n_out <= 1'b0;
    for (int i = 15; i >= 0; i--)
      bit_io(ins[i], b);
    for (int j = 0; j < n; j++) begin
      for (int i = 7; i >= 0; i--) begin
        bit_io(wd[8*j+i], b);
        q[i] = b;
      end
      if (rd) begin
        rd_byte_out <= q;
        rd_valid_out <= 1'b1;
        @(posedge ref_clk_in);
        rd_valid_out <= 1'b0;
      end
    end
    spi_sclk_out <= 1'b0;
    repeat (4) @(posedge ref_clk_in);
    spi_cs_n_out <= 1'b1;
    spi_sdi_out <= ~spi_sdi_out;
    repeat (3) @(posedge ref_clk_in);
  endtask
endmodule // spcr_host

// ### sim/spcr_regs_bench.sv
module spcr_regs_bench;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [3:0] CLS = 4'h9; // arbitrary value
  localparam logic [7:0] PART = 8'h5c; // arbitrary value
  logic ref_clk_in = 1'b0;
  logic srst_in = 1'b1;
  logic [4:0] conv_addr_in = 5'h00;
  wire spi_cs_n_in, spi_sclk_in, spi_sdi_in, spi_sdo_out, spi_sdo_oe_out;
  wire soft_reset_out, converter_load_out, converter_source_a_out;
  wire [1:0] power_state_out;
  wire [7:0] power_down_0_out, power_down_1_out, conv_data_out, rd_byte;
  wire rd_valid;
  int n_fail = 0;
  int num_checks = 0;
  logic [7:0] exp_q[$];
  logic [7:0] r1, r2, pde;
  logic [1:0] c;

  always #4 ref_clk_in = ~ref_clk_in;

  spcr_regs #(.CLASS_CODE(CLS), .PART_CODE_LOW(PART)) dut (
    .ref_clk_in, .srst_in, .spi_cs_n_in, .spi_sclk_in, .spi_sdi_in,
    .spi_sdo_out, .spi_sdo_oe_out, .soft_reset_out, .converter_load_out,
    .converter_source_a_out, .power_state_out, .power_down_0_out,
    .power_down_1_out, .conv_addr_in, .conv_data_out);
  spcr_host host (.ref_clk_in, .spi_sdo_in(spi_sdo_out),
    .spi_sdo_oe_in(spi_sdo_oe_out), .spi_cs_n_out(spi_cs_n_in),
    .spi_sclk_out(spi_sclk_in), .spi_sdi_out(spi_sdi_in),
    .rd_valid_out(rd_valid), .rd_byte_out(rd_byte));

  // ----------------
  // tasks
  // ----------------
  task automatic chk(input string nm, input logic [7:0] e,
                     input logic [7:0] g);
    num_checks++;
    if (g !== e) begin
      n_fail++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic rd(input logic [14:0] a, input int n, input logic [39:0] e);
    for (int i = 0; i < n; i++)
      exp_q.push_back(e[8*i +: 8]);
    host.xfer(1'b1, a, n, 40'h0);
  endtask
  task automatic wr(input logic [14:0] a, input int n, input logic [39:0] d);
    host.xfer(1'b0, a, n, d);
  endtask
  task automatic test_done;
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  always @(posedge ref_clk_in) begin
    if (rd_valid === 1'b1)
      chk("read data", exp_q.pop_front(), rd_byte);
  end

  initial begin
    repeat (20000) @(posedge ref_clk_in);
    n_fail++;
    test_done;
  end

  // ----------------
  // tests
  // ----------------
  initial begin
    void'($urandom(71));
    r1 = 8'($urandom) | 8'h01;
    r2 = 8'($urandom) | 8'h01;
    pde = 8'h00;
    repeat (20) @(posedge ref_clk_in);
    srst_in <= 1'b0;
    @(posedge ref_clk_in);
    rd(15'h0000, 5, {PART, 4'h0, CLS, 24'h030030});
    $display("test reset values done");
    for (int i = 0; i < 4; i++) begin
      c = 2'(8'b10_00_01_11 >> (2 * i));
      wr(15'h0002, 1, 40'(c));
      if (c == 2'h3)
        pde = 8'hff;
      if (c == 2'h0)
        pde = 8'h00;
      chk("power_state", 8'(c), 8'(power_state_out));
      chk("power_down_0", pde, power_down_0_out);
      chk("power_down_1", pde, power_down_1_out);
    end
    $display("test power state done");
    wr(15'h0003, 2, 40'hffff);
    rd(15'h0003, 2, {PART, 4'h0, CLS});
    rd(15'h0100, 1, 40'h0);
    $display("test read-only done");
    wr(15'h0000, 1, 40'h10);
    rd(15'h0001, 3, 40'h001000);
    wr(15'h0000, 1, 40'h30);
    rd(15'h7fff, 2, 40'h3000);
    $display("test address order done");
    wr(15'h0050, 1, 40'(r1));
    rd(15'h0050, 1, 40'h0);
    wr(15'h0001, 1, 40'h20);
    chk("source", 8'h01, 8'(converter_source_a_out));
    rd(15'h0050, 1, 40'(r1));
    chk("conv_data", 8'h00, conv_data_out);
    wr(15'h000f, 1, 40'h01);
    rd(15'h000f, 1, 40'h0);
    chk("conv_data", r1, conv_data_out);
    $display("test converter load done");
    wr(15'h0001, 1, 40'ha0);
    wr(15'h0051, 2, {8'hff, r2});
    // released sdo reads as the inverse of the held odd bit
    rd(15'h0051, 2, 40'({8'h00, r2}));
    wr(15'h0001, 1, 40'h20);
    rd(15'h0051, 2, 40'({8'h00, r2}));
    conv_addr_in <= 5'h01;
    wr(15'h000f, 1, 40'h01);
    chk("conv_data_1", r2, conv_data_out);
    $display("test single access done");
    wr(15'h0000, 1, 40'hb0);
    rd(15'h0000, 3, 40'h032030);
    rd(15'h0050, 1, 40'h0);
    chk("conv_data", 8'h00, conv_data_out);
    $display("test soft reset done");
    chk("pending reads", 8'h00, 8'(exp_q.size()));
    test_done;
  end
endmodule // spcr_regs_bench
